// >>> design/rail_group_fault_routing.sv
// Purpose: APB register bank assigning rails to groups and routing faults to responses.
// Assumes: Single clock pclk at 250 MHz; all inputs synchronous to pclk.
// Notes: Registers reset to zero; nvm_load copies the stored defaults in afterwards.
`timescale 1ns/10ps
module rail_group_fault_routing (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rail_group_pkg::ADDR_W-1:0] paddr,
	input wire logic [rail_group_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [rail_group_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic nvm_load,
	input wire logic [rail_group_pkg::REG_W-1:0] nvm_converter_default,
	input wire logic [rail_group_pkg::REG_W-1:0] nvm_monitor_default,
	input wire logic [rail_group_pkg::REG_W-1:0] nvm_response_default,
	input wire logic [rail_group_pkg::NUM_CONVERTERS-1:0] converter_fault,
	input wire logic [rail_group_pkg::NUM_MONITORS-1:0] monitor_fault,
	input wire logic severe_error,
	output logic [rail_group_pkg::NUM_GROUPS-1:0] group_fault,
	output logic immediate_shutdown_req,
	output logic orderly_shutdown_req,
	output logic mcu_power_error_req,
	output logic soc_power_error_req
);
	import rail_group_pkg::*;

	// ==========================================================================
	// State
	// All flops of the block live in one packed struct so that reset and
	// registering happen in exactly one place.
	typedef struct packed {
		logic [REG_W-1:0] conv;
		logic [REG_W-1:0] mon;
		logic [REG_W-1:0] resp;
		logic [DATA_W-1:0] rdata;
		logic ready;
		logic slverr;
		logic [NUM_GROUPS-1:0] gfault;
		logic [NUM_RESPONSES-1:0] req;
	} state_s;

	localparam state_s STATE_RST = '{
		conv: CONVERTER_GROUP_ASSIGN_RST,
		mon: MONITOR_GROUP_ASSIGN_RST,
		resp: FAULT_RESPONSE_SELECT_RST,
		rdata: '0,
		ready: 1'b0,
		slverr: 1'b0,
		gfault: '0,
		req: '0
	};

	state_s state_r;
	state_s state_nxt;

	// ==========================================================================
	// Address decode
	// One-hot select: bit 0 converter, bit 1 monitor, bit 2 response register.
	// Any other address, including one not word aligned, selects nothing.
	localparam int SEL_CONV = 0;
	localparam int SEL_MON = 1;
	localparam int SEL_RESP = 2;

	function automatic logic [2:0] reg_select(input logic [ADDR_W-1:0] a);
		logic [2:0] s;
		s = 3'h0;
		s[SEL_CONV] = (a == CONVERTER_GROUP_ASSIGN_ADDR);
		s[SEL_MON] = (a == MONITOR_GROUP_ASSIGN_ADDR);
		s[SEL_RESP] = (a == FAULT_RESPONSE_SELECT_ADDR);
		return s;
	endfunction

	logic setup_phase;
	logic access_done;
	logic [2:0] setup_sel;
	logic [2:0] access_sel;
	logic write_take;

	// Setup is the first cycle of a transfer; the access completes at the edge
	// where our own pready is high.
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & state_r.ready;
	assign setup_sel = reg_select(paddr);
	assign access_sel = reg_select(paddr);
	// Only byte lane 0 holds register bits, so a write without it is a no-op.
	assign write_take = access_done & pwrite & pstrb[0];

	// ==========================================================================
	// Named views of the fields
	logic [FIELD_W-1:0] converter_one_group_field;
	logic [FIELD_W-1:0] converter_two_group_field;
	logic [FIELD_W-1:0] converter_three_group_field;
	logic [FIELD_W-1:0] converter_four_group_field;
	logic [FIELD_W-1:0] first_monitor_group_field;
	logic [FIELD_W-1:0] second_monitor_group_field;
	logic [FIELD_W-1:0] analog_supply_monitor_group_field;
	logic [FIELD_W-1:0] severe_error_response;
	logic [FIELD_W-1:0] other_group_response;
	logic [FIELD_W-1:0] soc_group_response;
	logic [FIELD_W-1:0] mcu_group_response;

	assign converter_one_group_field = field_at(state_r.conv, CONVERTER_ONE_LSB);
	assign converter_two_group_field = field_at(state_r.conv, CONVERTER_TWO_LSB);
	assign converter_three_group_field = field_at(state_r.conv, CONVERTER_THREE_LSB);
	assign converter_four_group_field = field_at(state_r.conv, CONVERTER_FOUR_LSB);
	assign analog_supply_monitor_group_field = field_at(state_r.mon, ANALOG_MONITOR_LSB);
	assign first_monitor_group_field = field_at(state_r.mon, FIRST_MONITOR_LSB);
	assign second_monitor_group_field = field_at(state_r.mon, SECOND_MONITOR_LSB);
	assign severe_error_response = field_at(state_r.resp, SEVERE_RESPONSE_LSB);
	assign other_group_response = field_at(state_r.resp, OTHER_RESPONSE_LSB);
	assign soc_group_response = field_at(state_r.resp, SOC_RESPONSE_LSB);
	assign mcu_group_response = field_at(state_r.resp, MCU_RESPONSE_LSB);

	// ==========================================================================
	// Group fault collection
	logic [NUM_GROUPS-1:0] group_fault_now;

	rail_group_collect u_collect (
		.converter_group_r(state_r.conv),
		.monitor_group_r(state_r.mon),
		.converter_fault(converter_fault),
		.monitor_fault(monitor_fault),
		.group_fault(group_fault_now)
	);

	// ==========================================================================
	// Next-state logic
	// Register bank first, then the bus answer, then fault routing. A software
	// write in the same cycle as nvm_load wins for the register it targets, so
	// a driver never sees its own write silently overwritten.
	always_comb begin
		state_nxt = state_r;

		// Defaults from nonvolatile memory.
		if (nvm_load) begin
			state_nxt.conv = nvm_converter_default;
			state_nxt.mon = nvm_monitor_default;
			state_nxt.resp = nvm_response_default;
		end

		// Writes land only at the completing access edge.
		if (write_take) begin
			if (access_sel[SEL_CONV]) begin
				state_nxt.conv = pwdata[REG_W-1:0];
			end
			if (access_sel[SEL_MON]) begin
				state_nxt.mon = pwdata[REG_W-1:0];
			end
			if (access_sel[SEL_RESP]) begin
				state_nxt.resp = pwdata[REG_W-1:0];
			end
		end

		// pready rises for the first access cycle only: zero wait states.
		// Read data and the error flag are captured in the setup cycle.
		state_nxt.ready = setup_phase;
		state_nxt.slverr = setup_phase & ~(|setup_sel);
		state_nxt.rdata = '0;
		if (setup_phase && !pwrite) begin
			case (setup_sel)
				3'h1: state_nxt.rdata = {{DATA_PAD{1'b0}}, state_r.conv};
				3'h2: state_nxt.rdata = {{DATA_PAD{1'b0}}, state_r.mon};
				3'h4: state_nxt.rdata = {{DATA_PAD{1'b0}}, state_r.resp};
				default: state_nxt.rdata = '0;
			endcase
		end

		// Each faulted group raises the request its response field names.
		// Requests are levels that follow the faults with one cycle of delay.
		state_nxt.gfault = group_fault_now;
		state_nxt.req = '0;
		if (group_fault_now[MCU_BIT]) begin
			state_nxt.req[mcu_group_response] = 1'b1;
		end
		if (group_fault_now[SOC_BIT]) begin
			state_nxt.req[soc_group_response] = 1'b1;
		end
		if (group_fault_now[OTHER_BIT]) begin
			state_nxt.req[other_group_response] = 1'b1;
		end
		if (severe_error) begin
			state_nxt.req[severe_error_response] = 1'b1;
		end
	end

	// ==========================================================================
	// State register
	// Registers clear to zero; defaults only arrive through nvm_load.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= STATE_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================================
	// Outputs, each taken straight from a flop
	assign prdata = state_r.rdata;
	assign pready = state_r.ready;
	assign pslverr = state_r.slverr;
	assign group_fault = state_r.gfault;
	assign immediate_shutdown_req = state_r.req[RESP_IMMEDIATE];
	assign orderly_shutdown_req = state_r.req[RESP_ORDERLY];
	assign mcu_power_error_req = state_r.req[RESP_MCU_ERROR];
	assign soc_power_error_req = state_r.req[RESP_SOC_ERROR];

	// ==========================================================================
	// Assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// A completed write to the converter register shows on the next cycle.
	a_conv_write_lands: assert property (
		(write_take && paddr == CONVERTER_GROUP_ASSIGN_ADDR)
		|=> state_r.conv == $past(pwdata[REG_W-1:0]))
		else $error("converter group write did not land");

	// A completed write to the monitor register keeps every bit, reserved ones too.
	a_mon_write_lands: assert property (
		(write_take && paddr == MONITOR_GROUP_ASSIGN_ADDR)
		|=> state_r.mon == $past(pwdata[REG_W-1:0]))
		else $error("monitor group write did not land");

	// A response register write, an idle bus cycle, then a read of it returns
	// the written byte.
	a_resp_roundtrip: assert property (
		(write_take && paddr == FAULT_RESPONSE_SELECT_ADDR) ##1 (!psel && !nvm_load) ##1
		(setup_phase && !pwrite && paddr == FAULT_RESPONSE_SELECT_ADDR && !nvm_load)
		|=> prdata == {{DATA_PAD{1'b0}}, $past(pwdata[REG_W-1:0], 3)})
		else $error("response register read back differs from written value");

	// An nvm_load with no competing write installs the stored defaults.
	a_nvm_defaults: assert property (
		(nvm_load && !write_take)
		|=> state_r.conv == $past(nvm_converter_default)
		&& state_r.mon == $past(nvm_monitor_default)
		&& state_r.resp == $past(nvm_response_default))
		else $error("defaults not loaded from memory");

	// Every setup cycle is answered by exactly one pready cycle.
	a_ready_single: assert property (
		setup_phase |=> pready ##1 !pready)
		else $error("pready not a single cycle after setup");

	// An unmapped address raises pslverr together with pready and changes nothing.
	// A load from memory in the access cycle may still change the registers.
	a_unmapped_error: assert property (
		(setup_phase && reg_select(paddr) == 3'h0) ##1 !nvm_load
		|-> pslverr && pready
		##1 $stable(state_r.conv) && $stable(state_r.mon) && $stable(state_r.resp))
		else $error("unmapped access not flagged or not ignored");

	// The severe error raises the request its field selects one cycle later.
	a_severe_route: assert property (
		severe_error |=> state_r.req[$past(severe_error_response)])
		else $error("severe error response not raised");

	// An MCU group fault raises the response chosen by bits 1:0.
	a_mcu_route: assert property (
		state_r.gfault[MCU_BIT] |-> state_r.req[$past(mcu_group_response)])
		else $error("MCU group response not raised");

	// A SOC group fault raises the response chosen by bits 3:2.
	a_soc_route: assert property (
		state_r.gfault[SOC_BIT] |-> state_r.req[$past(soc_group_response)])
		else $error("SOC group response not raised");

	// An OTHER group fault raises the response chosen by bits 5:4.
	a_other_route: assert property (
		state_r.gfault[OTHER_BIT] |-> state_r.req[$past(other_group_response)])
		else $error("OTHER group response not raised");

	// Converter one assigned to the MCU group drives that group's fault.
	a_conv_mcu_hit: assert property (
		(converter_fault[0] && converter_one_group_field == GROUP_MCU)
		|=> group_fault[MCU_BIT])
		else $error("converter one fault missed the MCU group");

	// The analog supply monitor in the OTHER group drives only that group.
	a_mon_other_hit: assert property (
		(monitor_fault == 3'h1 && converter_fault == '0
		&& analog_supply_monitor_group_field == GROUP_OTHER)
		|=> group_fault == 3'h4)
		else $error("analog monitor fault routed to the wrong group");

	// A lone fault on an unassigned rail raises no group and no request.
	a_unassigned_silent: assert property (
		(converter_fault == 4'h1 && monitor_fault == '0 && !severe_error
		&& converter_one_group_field == GROUP_NONE)
		|=> group_fault == '0 && state_r.req == '0)
		else $error("unassigned rail triggered a response");

	// Requests drop one cycle after every cause has gone away.
	a_requests_clear: assert property (
		(converter_fault == '0 && monitor_fault == '0 && !severe_error)
		|=> state_r.req == '0)
		else $error("request held without a cause");

	// Reads answer for one cycle only; at every other time the read bus is zero.
	a_rdata_idle: assert property (
		!(setup_phase && !pwrite) |=> prdata == '0)
		else $error("read data not zero outside the read answer");

	// A mapped address never raises the error flag.
	a_mapped_no_error: assert property (
		(setup_phase && reg_select(paddr) != 3'h0) |=> !pslverr)
		else $error("mapped access flagged as an error");

	// The fourth converter assigned to the OTHER group drives only that group.
	a_conv_four_other: assert property (
		(converter_fault == 4'h8 && monitor_fault == '0
		&& converter_four_group_field == GROUP_OTHER)
		|=> group_fault == 3'h4)
		else $error("converter four fault routed to the wrong group");

	// The second monitor assigned to the SOC group drives only that group.
	a_mon_two_soc: assert property (
		(monitor_fault == 3'h4 && converter_fault == '0
		&& second_monitor_group_field == GROUP_SOC)
		|=> group_fault == 3'h2)
		else $error("second monitor fault routed to the wrong group");

	// Code one of the severe error field reaches the orderly shutdown pin, which
	// catches a swap between the response codes and the request pins.
	a_orderly_code: assert property (
		(severe_error && severe_error_response == RESP_ORDERLY) |=> orderly_shutdown_req)
		else $error("orderly shutdown code did not reach its pin");

	// ==========================================================================
	// Coverage of the main scenarios
	c_conv_write: cover property (write_take && paddr == CONVERTER_GROUP_ASSIGN_ADDR);
	c_severe_soc: cover property (severe_error && severe_error_response == RESP_SOC_ERROR);
	c_soc_group: cover property (state_r.gfault[SOC_BIT] && soc_power_error_req);
	c_unmapped: cover property (pready && pslverr);
	c_nvm_load: cover property (nvm_load && !write_take);

endmodule

// >>> include/rail_group_pkg.sv
// Purpose: Shared constants, encodings and helpers for the rail group fault routing block.
// Assumes: APB with 32-bit data, one aligned word per register, byte address = 4 * index.
// Notes: Only the low byte of each word carries register bits; the rest reads as zero.
package rail_group_pkg;

	// ==========================================================================
	// Bus and register widths
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	localparam int REG_W = 8;
	localparam int FIELD_W = 2;
	localparam int DATA_PAD = DATA_W - REG_W;

	// ==========================================================================
	// Register indices, and their byte addresses at four times the index
	localparam logic [9:0] CONVERTER_GROUP_ASSIGN_IDX = 10'h041;
	localparam logic [9:0] MONITOR_GROUP_ASSIGN_IDX = 10'h043;
	localparam logic [9:0] FAULT_RESPONSE_SELECT_IDX = 10'h044;
	localparam logic [ADDR_W-1:0] CONVERTER_GROUP_ASSIGN_ADDR = {CONVERTER_GROUP_ASSIGN_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] MONITOR_GROUP_ASSIGN_ADDR = {MONITOR_GROUP_ASSIGN_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] FAULT_RESPONSE_SELECT_ADDR = {FAULT_RESPONSE_SELECT_IDX, 2'h0};

	// ==========================================================================
	// Reset values
	localparam logic [REG_W-1:0] CONVERTER_GROUP_ASSIGN_RST = 8'h00;
	localparam logic [REG_W-1:0] MONITOR_GROUP_ASSIGN_RST = 8'h00;
	localparam logic [REG_W-1:0] FAULT_RESPONSE_SELECT_RST = 8'h00;

	// ==========================================================================
	// Field positions (low bit of each two-bit field)
	localparam int CONVERTER_ONE_LSB = 0;
	localparam int CONVERTER_TWO_LSB = 2;
	localparam int CONVERTER_THREE_LSB = 4;
	localparam int CONVERTER_FOUR_LSB = 6;
	localparam int ANALOG_MONITOR_LSB = 2;
	localparam int FIRST_MONITOR_LSB = 4;
	localparam int SECOND_MONITOR_LSB = 6;
	localparam int MCU_RESPONSE_LSB = 0;
	localparam int SOC_RESPONSE_LSB = 2;
	localparam int OTHER_RESPONSE_LSB = 4;
	localparam int SEVERE_RESPONSE_LSB = 6;

	// ==========================================================================
	// Group codes; group bit index g stands for code g + 1
	localparam logic [1:0] GROUP_NONE = 2'h0;
	localparam logic [1:0] GROUP_MCU = 2'h1;
	localparam logic [1:0] GROUP_SOC = 2'h2;
	localparam logic [1:0] GROUP_OTHER = 2'h3;
	localparam int NUM_GROUPS = 3;
	localparam int MCU_BIT = 0;
	localparam int SOC_BIT = 1;
	localparam int OTHER_BIT = 2;

	// ==========================================================================
	// Response codes, also the bit index of each request output
	localparam logic [1:0] RESP_IMMEDIATE = 2'h0;
	localparam logic [1:0] RESP_ORDERLY = 2'h1;
	localparam logic [1:0] RESP_MCU_ERROR = 2'h2;
	localparam logic [1:0] RESP_SOC_ERROR = 2'h3;
	localparam int NUM_RESPONSES = 4;

	// ==========================================================================
	// Rail counts
	localparam int NUM_CONVERTERS = 4;
	localparam int NUM_MONITORS = 3;

	// Pulls one two-bit field out of a register byte.
	function automatic logic [FIELD_W-1:0] field_at(input logic [REG_W-1:0] r, input int lsb);
		return r[lsb +: FIELD_W];
	endfunction

	// True when a rail's group field names the group with bit index g.
	function automatic logic group_hit(input logic [FIELD_W-1:0] field, input int g);
		return field == FIELD_W'(g + 1);
	endfunction

endpackage

// >>> design/rail_group_collect.sv
// Purpose: Gathers rail faults into one fault level per rail group.
// Assumes: Fault inputs are synchronous levels; pure combinational logic.
// Notes: A rail whose field holds the no-group code contributes to no group.
`timescale 1ns/10ps
module rail_group_collect (
	input wire logic [rail_group_pkg::REG_W-1:0] converter_group_r,
	input wire logic [rail_group_pkg::REG_W-1:0] monitor_group_r,
	input wire logic [rail_group_pkg::NUM_CONVERTERS-1:0] converter_fault,
	input wire logic [rail_group_pkg::NUM_MONITORS-1:0] monitor_fault,
	output logic [rail_group_pkg::NUM_GROUPS-1:0] group_fault
);
	import rail_group_pkg::*;

	// ==========================================================================
	// Membership of every rail in every group
	logic [NUM_CONVERTERS-1:0] conv_member [NUM_GROUPS];
	logic [NUM_MONITORS-1:0] mon_member [NUM_GROUPS];

	// Converter n sits at bits n*2; monitors sit one field higher, so that the
	// reserved low field of the monitor register never maps to a rail.
	genvar g, n;
	generate
		for (g = 0; g < NUM_GROUPS; g++) begin : grp
			for (n = 0; n < NUM_CONVERTERS; n++) begin : conv
				assign conv_member[g][n] = group_hit(field_at(converter_group_r, n * FIELD_W), g);
			end
			for (n = 0; n < NUM_MONITORS; n++) begin : mon
				assign mon_member[g][n] = group_hit(field_at(monitor_group_r, (n + 1) * FIELD_W), g);
			end
			// A group is in fault when any of its member rails is.
			assign group_fault[g] = |(conv_member[g] & converter_fault) | |(mon_member[g] & monitor_fault);
		end
	endgenerate

endmodule

// >>> tb/test_rail_group_fault_routing.sv
// Purpose: Self-checking bench for the rail group fault routing register bank.
// Assumes: Zero-wait APB slave; fault outputs lag inputs by one edge.
// Notes: Every register access goes through one APB task; every compare through chk.
`timescale 1ns/10ps
module test_rail_group_fault_routing;
	import rail_group_pkg::*;

	// ==========================================================================
	// Stimulus and observation signals
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nvm_load, severe_error;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [REG_W-1:0] nvm_conv, nvm_mon, nvm_resp;
	logic [NUM_CONVERTERS-1:0] converter_fault;
	logic [NUM_MONITORS-1:0] monitor_fault;
	logic [NUM_GROUPS-1:0] group_fault;
	logic imm_req, ord_req, mcu_req, soc_req, er;
	int mismatches, tests_run;
	// Group bits 6:4 and request bits 3:0 expected for each group code, with responses 8'h1e.
	logic [6:0] exp_by_code [0:3] = '{7'h00, 7'h14, 7'h28, 7'h42};
	logic [ADDR_W-1:0] reg_addr [0:2] = '{CONVERTER_GROUP_ASSIGN_ADDR,
		MONITOR_GROUP_ASSIGN_ADDR, FAULT_RESPONSE_SELECT_ADDR};
	logic [31:0] wr_val [0:2] = '{32'hdead_be93, 32'h1234_56c7, 32'hffff_ff6c};
	wire [31:0] seen = {25'h0, group_fault, soc_req, mcu_req, ord_req, imm_req};

	rail_group_fault_routing DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_load(nvm_load),
		.nvm_converter_default(nvm_conv), .nvm_monitor_default(nvm_mon),
		.nvm_response_default(nvm_resp), .converter_fault(converter_fault),
		.monitor_fault(monitor_fault), .severe_error(severe_error), .group_fault(group_fault),
		.immediate_shutdown_req(imm_req), .orderly_shutdown_req(ord_req),
		.mcu_power_error_req(mcu_req), .soc_power_error_req(soc_req));

	// ==========================================================================
	// Shared tasks
	// Prints the counts and the verdict, then stops the run.
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the wait for pready is bounded so a dead slave ends the run.
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			mismatches++;
			complete_run();
		end
	endtask

	// Faults are sampled at the next edge and show one cycle later.
	task automatic drive_faults(input logic [3:0] cf, input logic [2:0] mf, input logic sev);
		@(posedge pclk);
		converter_fault <= cf;
		monitor_fault <= mf;
		severe_error <= sev;
		repeat (2) @(posedge pclk);
		#1;
	endtask

	// ==========================================================================
	// Scenarios
	// Reset values, idle outputs, and an unmapped word between the two group registers.
	task automatic reset_values();
		chk(seen, 32'h0);
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, reg_addr[i], 32'h0, 4'h0);
			chk(rd, 32'h0);
			chk({31'h0, er}, 32'h0);
		end
		apb(1'b0, 12'h108, 32'h0, 4'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
	endtask

	// Only the low byte is kept, reserved monitor bits too, and a write without lane 0 is ignored.
	task automatic readback();
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, reg_addr[i], wr_val[i], 4'hf);
			apb(1'b0, reg_addr[i], 32'h0, 4'h0);
			chk(rd, {24'h0, wr_val[i][7:0]});
			apb(1'b1, reg_addr[i], 32'h0, 4'he);
			apb(1'b0, reg_addr[i], 32'h0, 4'h0);
			chk(rd, {24'h0, wr_val[i][7:0]});
		end
	endtask

	// Stored defaults overwrite all three registers while the load strobe is high.
	task automatic nvm_defaults();
		@(posedge pclk);
		nvm_load <= 1'b1;
		@(posedge pclk);
		nvm_load <= 1'b0;
		apb(1'b0, CONVERTER_GROUP_ASSIGN_ADDR, 32'h0, 4'h0);
		chk(rd, 32'h5a);
		apb(1'b0, MONITOR_GROUP_ASSIGN_ADDR, 32'h0, 4'h0);
		chk(rd, 32'ha5);
		apb(1'b0, FAULT_RESPONSE_SELECT_ADDR, 32'h0, 4'h0);
		chk(rd, 32'h3c);
	endtask

	// Every rail in every group code; each group has its own response so a swap shows.
	task automatic rail_routing();
		apb(1'b1, FAULT_RESPONSE_SELECT_ADDR, 32'h1e, 4'h1);
		for (int c = 0; c < 4; c++) begin
			for (int n = 0; n < 7; n++) begin
				apb(1'b1, CONVERTER_GROUP_ASSIGN_ADDR, (n < 4) ? 32'(c) << (2 * n) : 32'h0, 4'h1);
				apb(1'b1, MONITOR_GROUP_ASSIGN_ADDR, (n < 4) ? 32'h0 : 32'(c) << (2 * (n - 3)), 4'h1);
				drive_faults((n < 4) ? 4'(1 << n) : 4'h0, (n < 4) ? 3'h0 : 3'(1 << (n - 4)), 1'b0);
				chk(seen, {25'h0, exp_by_code[c]});
				drive_faults(4'h0, 3'h0, 1'b0);
				chk(seen, 32'h0);
			end
		end
	endtask

	// Each response code selected for a severe error raises exactly its own request.
	task automatic severe_codes();
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, FAULT_RESPONSE_SELECT_ADDR, 32'(r) << 6, 4'h1);
			drive_faults(4'h0, 3'h0, 1'b1);
			chk(seen, 32'(1) << r);
			drive_faults(4'h0, 3'h0, 1'b0);
		end
	endtask

	// ==========================================================================
	// Clock at 4 ns period.
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// Main sequence: all inputs defined at time zero, reset held for six cycles.
	initial begin
		mismatches = 0;
		tests_run = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, nvm_load, severe_error} = 5'h0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'h0;
		nvm_conv = 8'h5a;
		nvm_mon = 8'ha5;
		nvm_resp = 8'h3c;
		converter_fault = '0;
		monitor_fault = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		reset_values();
		readback();
		nvm_defaults();
		rail_routing();
		severe_codes();
		complete_run();
	end
endmodule
